// ==== hdl/tzf_pkg.sv ====
// constants shared by the torque meter front end control logic
// assumes a wishbone classic master and one 10 MHz clock
// Operation
// - panel key flips direction when remote off
// - remote on: direction from external contact
// - contact open/high clockwise, closed/low counterclockwise
// - zero request ignored while clear closed
// - zero key: flag, capture offset, drop flag
// - capacity torque maps to signed ten volts
// - maximum speed maps to plus ten volts
// - exponential average reaches 63 percent at tau
// - first order low pass, fc near 1/(2 pi tau)
// - mode key toggles; two confirms reach speed zero
// - zero step outputs zero, takes 0..+-0.999 V
// - full step outputs full scale, takes 9..10.999 V
// - clear closed forces both output values and the filter to zero
// - ready only in measure, torque present, clear open
package tzf_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] STAT_OFS = 5'h04;
  localparam logic [4:0] TCAP_OFS = 5'h08;
  localparam logic [4:0] SMAX_OFS = 5'h0C;
  localparam logic [4:0] CENT_OFS = 5'h10;
  localparam logic [4:0] ZOFS_OFS = 5'h14;
  localparam logic [4:0] TOUT_OFS = 5'h18;
  localparam logic [4:0] SOUT_OFS = 5'h1C;
  localparam int CTRL_RDIR_BIT  = 0;
  localparam int CTRL_SHIFT_LSB = 8;
  localparam int STAT_CCW_BIT   = 0;
  localparam int STAT_ZERO_BIT  = 1;
  localparam int STAT_CAL_BIT   = 2;
  localparam int STAT_STEP_LSB  = 3;
  localparam int STAT_RDY_BIT   = 5;
  // ****************
  // reset values
  // ****************
  localparam logic        CTRL_RDIR_RST  = 1'b0;
  localparam logic [3:0]  CTRL_SHIFT_RST = 4'h4;
  localparam logic [15:0] TCAP_RST       = 16'h7FFF;
  localparam logic [15:0] SMAX_RST       = 16'h2710;
  // ****************
  // output scale in millivolt codes
  // ****************
  localparam logic signed [15:0] FS_MV     = 16'sh2710;
  localparam logic signed [15:0] ZERO_LIM  = 16'sh03E7;
  localparam logic signed [15:0] FULL_MIN  = 16'sh2328;
  localparam logic signed [15:0] FULL_MAX  = 16'sh2AF7;
  // 63 percent settle of the average, for reference
  localparam int TAU_EX_MS = 16;
  typedef enum logic [1:0] {
    CAL_TZ = 2'b00,
    CAL_TF = 2'b01,
    CAL_SZ = 2'b10,
    CAL_SF = 2'b11
  } tzf_cal_type;
endpackage

// ==== hdl/tzf_flt_if.sv ====
// link between control block and its averaging filter
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface tzf_flt_if;
  logic               smp_vld;
  logic signed [17:0] smp;
  logic        [3:0]  shift;
  logic               clr;
  logic signed [17:0] flt;
  modport src (output smp_vld, output smp, output shift, output clr, input flt);
  modport flt_end (input smp_vld, input smp, input shift, input clr, output flt);
endinterface
`default_nettype wire

// ==== hdl/tzf_filter.sv ====
// exponential averaging low pass on torque samples
// assumes a sample strobe of one cycle per sample
`timescale 1ns/1ps
`default_nettype none
module tzf_filter (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  tzf_flt_if.flt_end f
);
  // eight fraction bits keep small steps from stalling
  logic signed [25:0] acc_q;
  logic signed [25:0] diff;

  assign diff = {f.smp, 8'h00} - acc_q;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i || f.clr)
      acc_q <= 26'sh0;
    else if (f.smp_vld)
      acc_q <= acc_q + (diff >>> f.shift);
  end

  assign f.flt = acc_q[25:8];
endmodule
`default_nettype wire

// ==== hdl/tzf_top.sv ====
// direction, zero capture, filter and analog output control
// assumes synchronous key levels and a wishbone classic master
`timescale 1ns/1ps
`default_nettype none
module tzf_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        direction_toggle_key_i,
  input  wire logic        zero_capture_key_i,
  input  wire logic        measure_calibrate_key_i,
  input  wire logic        enter_key_i,
  input  wire logic        remote_direction_i,
  input  wire logic        remote_clear_input_b_i,
  input  wire logic        torque_present_indicator_i,
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] torque_sample_i,
  input  wire logic [15:0] speed_sample_i,
  output logic [15:0]      torque_voltage_output_o,
  output logic [15:0]      speed_voltage_output_o,
  output logic             counterclockwise_o,
  output logic             zeroing_o,
  output logic             ready_o
);
  // ****************
  // helpers
  // ****************
  function automatic logic signed [31:0] scale(input logic signed [31:0] x,
                                               input logic signed [31:0] num,
                                               input logic signed [31:0] den);
    if (den == 32'sh0)
      return 32'sh0;
    return (x * num) / den;
  endfunction

  function automatic logic signed [15:0] sat(input logic signed [31:0] x,
                                             input logic signed [15:0] lo,
                                             input logic signed [15:0] hi);
    if (x < 32'(lo))
      return lo;
    if (x > 32'(hi))
      return hi;
    return x[15:0];
  endfunction

  function automatic logic [15:0] wmask(input logic [15:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    return {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  // ****************
  // state
  // ****************
  logic              rdir_q;
  logic [3:0]        shift_q;
  logic [15:0]       tcap_q;
  logic [15:0]       smax_q;
  logic [15:0]       cent_q;
  logic signed [17:0] zofs_q;
  logic signed [17:0] raw_q;
  logic              ccw_key_q;
  logic              zeroing_q;
  logic              cal_q;
  tzf_pkg::tzf_cal_type step_q;
  logic signed [15:0] tz_q;
  logic signed [15:0] tf_q;
  logic signed [15:0] sz_q;
  logic signed [15:0] sf_q;
  logic [3:0]        key_q;
  logic              ack_q;
  logic [31:0]       rdat_q;
  logic [15:0]       tout_q;
  logic [15:0]       sout_q;
  logic              ccw_q;
  logic              rdy_q;

  logic [3:0]  key_rise;
  logic        dir_rise;
  logic        zero_rise;
  logic        mode_rise;
  logic        ent_rise;
  logic        clr_closed;
  logic        counterclockwise;
  logic        wr;
  logic        rd_go;
  logic signed [15:0] ent;
  logic        ent_zero_ok;
  logic        ent_full_ok;
  logic signed [17:0] signed_smp;
  logic signed [31:0] trq_sc;
  logic signed [31:0] spd_sc;
  logic signed [15:0] trq_fs;
  logic signed [15:0] spd_fs;
  logic signed [15:0] trq_code;
  logic signed [15:0] spd_code;

  tzf_flt_if fif ();

  assign key_rise  = {direction_toggle_key_i, zero_capture_key_i,
                      measure_calibrate_key_i, enter_key_i} & ~key_q;
  assign dir_rise  = key_rise[3];
  assign zero_rise = key_rise[2];
  assign mode_rise = key_rise[1];
  assign ent_rise  = key_rise[0];
  assign clr_closed = !remote_clear_input_b_i;
  assign counterclockwise = rdir_q ? !remote_direction_i : ccw_key_q;
  assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign rd_go = wb_cyc_i && wb_stb_i && !ack_q;
  assign ent   = cent_q;
  assign ent_zero_ok = (ent <= tzf_pkg::ZERO_LIM) && (ent >= -tzf_pkg::ZERO_LIM);
  assign ent_full_ok = (ent >= tzf_pkg::FULL_MIN) && (ent <= tzf_pkg::FULL_MAX);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      key_q <= 4'h0;
    else
      key_q <= {direction_toggle_key_i, zero_capture_key_i,
                measure_calibrate_key_i, enter_key_i};
  end

  // ****************
  // wishbone slave
  // ****************
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      rdir_q  <= tzf_pkg::CTRL_RDIR_RST;
      shift_q <= tzf_pkg::CTRL_SHIFT_RST;
      tcap_q  <= tzf_pkg::TCAP_RST;
      smax_q  <= tzf_pkg::SMAX_RST;
      cent_q  <= 16'h0000;
    end
    else if (wr)
    begin
      if (wb_adr_i == tzf_pkg::CTRL_OFS)
      begin
        if (wb_sel_i[0])
          rdir_q <= wb_dat_i[tzf_pkg::CTRL_RDIR_BIT];
        if (wb_sel_i[1])
          shift_q <= wb_dat_i[tzf_pkg::CTRL_SHIFT_LSB +: 4];
      end
      else if (wb_adr_i == tzf_pkg::TCAP_OFS)
        tcap_q <= wmask(tcap_q, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == tzf_pkg::SMAX_OFS)
        smax_q <= wmask(smax_q, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == tzf_pkg::CENT_OFS)
        cent_q <= wmask(cent_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= rd_go;
      rdat_q <= 32'h0000_0000;
      if (wb_adr_i == tzf_pkg::CTRL_OFS)
        rdat_q <= {20'h0, shift_q, 7'h0, rdir_q};
      else if (wb_adr_i == tzf_pkg::STAT_OFS)
        rdat_q <= {26'h0, rdy_q, step_q, cal_q, zeroing_q, ccw_q};
      else if (wb_adr_i == tzf_pkg::TCAP_OFS)
        rdat_q <= {16'h0, tcap_q};
      else if (wb_adr_i == tzf_pkg::SMAX_OFS)
        rdat_q <= {16'h0, smax_q};
      else if (wb_adr_i == tzf_pkg::CENT_OFS)
        rdat_q <= {16'h0, cent_q};
      else if (wb_adr_i == tzf_pkg::ZOFS_OFS)
        rdat_q <= {{14{zofs_q[17]}}, zofs_q};
      else if (wb_adr_i == tzf_pkg::TOUT_OFS)
        rdat_q <= {{16{tout_q[15]}}, tout_q};
      else if (wb_adr_i == tzf_pkg::SOUT_OFS)
        rdat_q <= {16'h0, sout_q};
    end
  end

  // ****************
  // direction and zero capture
  // ****************
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      ccw_key_q <= 1'b0;
    else if (!rdir_q && dir_rise)
      ccw_key_q <= !ccw_key_q;
  end

  assign signed_smp = counterclockwise ? -18'(signed'(torque_sample_i))
                          : 18'(signed'(torque_sample_i));

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      raw_q <= 18'sh0;
    else if (sample_valid_i)
      raw_q <= signed_smp;
  end

  // offset taken one cycle after the flag rises, flag drops with it
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      zeroing_q <= 1'b0;
      zofs_q    <= 18'sh0;
    end
    else if (zeroing_q)
    begin
      zofs_q    <= raw_q;
      zeroing_q <= 1'b0;
    end
    else if (zero_rise && !clr_closed)
      zeroing_q <= 1'b1;
  end

  // ****************
  // filter
  // ****************
  assign fif.smp_vld = sample_valid_i;
  assign fif.smp     = signed_smp - zofs_q;
  assign fif.shift   = shift_q;
  assign fif.clr     = clr_closed;

  tzf_filter u_flt (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .f          (fif.flt_end)
  );

  // ****************
  // calibration sequence
  // ****************
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      cal_q  <= 1'b0;
      step_q <= tzf_pkg::CAL_TZ;
      tz_q   <= 16'sh0;
      sz_q   <= 16'sh0;
      tf_q   <= tzf_pkg::FS_MV;
      sf_q   <= tzf_pkg::FS_MV;
    end
    else if (mode_rise)
    begin
      cal_q  <= !cal_q;
      step_q <= tzf_pkg::CAL_TZ;
    end
    else if (cal_q && ent_rise)
    begin
      // out of range entries are refused, step holds
      case (step_q)
        tzf_pkg::CAL_TZ:
          if (ent_zero_ok)
          begin
            tz_q   <= ent;
            step_q <= tzf_pkg::CAL_TF;
          end
        tzf_pkg::CAL_TF:
          if (ent_full_ok)
          begin
            tf_q   <= ent;
            step_q <= tzf_pkg::CAL_SZ;
          end
        tzf_pkg::CAL_SZ:
          if (ent_zero_ok)
          begin
            sz_q   <= ent;
            step_q <= tzf_pkg::CAL_SF;
          end
        default:
          if (ent_full_ok)
            sf_q <= ent;
      endcase
    end
  end

  // ****************
  // output scaling
  // ****************
  assign trq_sc = scale(32'(fif.flt), 32'(tzf_pkg::FS_MV), 32'(tcap_q));
  assign spd_sc = scale(32'(speed_sample_i), 32'(tzf_pkg::FS_MV), 32'(smax_q));
  assign trq_fs = sat(trq_sc, -tzf_pkg::FULL_MAX, tzf_pkg::FULL_MAX);
  assign spd_fs = sat(spd_sc, 16'sh0, tzf_pkg::FULL_MAX);
  assign trq_code = sat(scale(32'(trq_fs) - 32'(tz_q), 32'(tzf_pkg::FS_MV), 32'(tf_q)),
                        -tzf_pkg::FULL_MAX, tzf_pkg::FULL_MAX);
  assign spd_code = sat(scale(32'(spd_fs) - 32'(sz_q), 32'(tzf_pkg::FS_MV), 32'(sf_q)),
                        16'sh0, tzf_pkg::FULL_MAX);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i || clr_closed)
    begin
      tout_q <= 16'h0000;
      sout_q <= 16'h0000;
    end
    else if (cal_q)
    begin
      // raw levels let the voltmeter see the uncorrected error
      tout_q <= (step_q == tzf_pkg::CAL_TF) ? tzf_pkg::FS_MV : 16'h0000;
      sout_q <= (step_q == tzf_pkg::CAL_SF) ? tzf_pkg::FS_MV : 16'h0000;
    end
    else
    begin
      tout_q <= trq_code;
      sout_q <= spd_code;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      ccw_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      ccw_q <= counterclockwise;
      rdy_q <= !cal_q && torque_present_indicator_i && !clr_closed;
    end
  end

  assign wb_ack_o                = ack_q;
  assign wb_dat_o                = rdat_q;
  assign torque_voltage_output_o = tout_q;
  assign speed_voltage_output_o  = sout_q;
  assign counterclockwise_o      = ccw_q;
  assign zeroing_o               = zeroing_q;
  assign ready_o                 = rdy_q;

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence zero_req_s;
    zero_rise && !clr_closed && !zeroing_q;
  endsequence
  sequence zero_done_s;
    zeroing_q ##1 (!zeroing_q && zofs_q == $past(raw_q));
  endsequence

  key_flip_a: assert property (!rdir_q && dir_rise |=> ccw_key_q != $past(ccw_key_q))
    else $error("panel key did not flip direction");
  remote_dir_a: assert property (rdir_q |=> ccw_q == !$past(remote_direction_i))
    else $error("remote direction decode wrong");
  zero_block_a: assert property (clr_closed && !zeroing_q
                                 |=> $stable(zofs_q) && !zeroing_q)
    else $error("zero taken while clear closed");
  zero_seq_a: assert property (zero_req_s |=> zero_done_s)
    else $error("zero capture sequence broken");
  clear_out_a: assert property (clr_closed
                                |=> tout_q == 16'h0000 && sout_q == 16'h0000)
    else $error("outputs not forced to zero");
  ready_a: assert property (##1 rdy_q == $past(!cal_q && torque_present_indicator_i
                                               && !clr_closed))
    else $error("ready contact wrong");
  cal_step_a: assert property (cal_q && !mode_rise && ent_rise
                               && step_q == tzf_pkg::CAL_TZ && ent_zero_ok
                               |=> step_q == tzf_pkg::CAL_TF ##0 tz_q == $past(ent))
    else $error("zero confirm did not advance");
  cal_full_a: assert property (cal_q && step_q == tzf_pkg::CAL_TF && !clr_closed
                               |=> tout_q == tzf_pkg::FS_MV)
    else $error("full scale not driven");
  cal_zero_a: assert property (cal_q && step_q == tzf_pkg::CAL_TZ
                               |=> tout_q == 16'h0000)
    else $error("zero level not driven");
  wb_ack_a: assert property (ack_q |=> !ack_q)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

// ==== test/tzf_remote_model.sv ====
// external contact model for remote direction and clear inputs
// assumes contacts move slowly against the core clock
`timescale 1ns/1ps
`default_nettype none
module tzf_remote_model #(
  parameter int LAG = 2
) (
  input  wire logic core_clk_i,
  input  wire logic dir_closed_i,
  input  wire logic clr_closed_i,
  output logic      remote_direction_o,
  output logic      remote_clear_b_o
);
  logic [LAG-1:0] dir_q = '1;
  logic [LAG-1:0] clr_q = '1;
  // pulled-up contacts: open reads high, closed pulls low
  // lag mimics a relay that settles a few cycles late
  always_ff @(posedge core_clk_i)
  begin
    dir_q <= {dir_q[LAG-2:0], ~dir_closed_i};
    clr_q <= {clr_q[LAG-2:0], ~clr_closed_i};
  end
  assign remote_direction_o = dir_q[LAG-1];
  assign remote_clear_b_o   = clr_q[LAG-1];
endmodule
`default_nettype wire

// ==== test/tzf_top_tb.sv ====
// self-checking bench for the torque meter front end control
// assumes the contact model stands on the remote inputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  n_tests++; \
  if ((g) !== (e)) \
  begin \
    error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); \
  end
module tzf_top_tb;
  logic        clk, rst_b, cyc, stb, we, ack, present, sv, dir_c, clr_c;
  logic        rdir, rclr_b, counterclockwise, zeroing, ready;
  logic [4:0]  adr;
  logic [3:0]  sel, keys;
  logic [31:0] wdat, rdat, dat_o;
  logic [15:0] tq, spd, tout, sout;
  int          error_cnt, n_tests, cyc_n, zcnt, z0;

  tzf_top uut (
    .core_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .direction_toggle_key_i(keys[0]),
    .zero_capture_key_i(keys[1]), .measure_calibrate_key_i(keys[2]),
    .enter_key_i(keys[3]), .remote_direction_i(rdir),
    .remote_clear_input_b_i(rclr_b), .torque_present_indicator_i(present),
    .sample_valid_i(sv), .torque_sample_i(tq), .speed_sample_i(spd),
    .torque_voltage_output_o(tout), .speed_voltage_output_o(sout),
    .counterclockwise_o(counterclockwise), .zeroing_o(zeroing), .ready_o(ready)
  );
  tzf_remote_model #(.LAG(2)) remote (
    .core_clk_i(clk), .dir_closed_i(dir_c), .clr_closed_i(clr_c),
    .remote_direction_o(rdir), .remote_clear_b_o(rclr_b)
  );

  // ****
  // clock, timeout, zero pulse counter
  // ****
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc_n++;
    if (zeroing === 1'b1) zcnt++;
    if (cyc_n == 5000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // ****
  // tasks
  // ****
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    if (n >= 50) error_cnt++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic key(input int i);
    @(posedge clk);
    keys[i] <= 1'b1;
    @(posedge clk);
    keys[i] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic smp(input logic [15:0] t, input int n);
    repeat (n)
    begin
      @(posedge clk);
      sv <= 1'b1;
      tq <= t;
      @(posedge clk);
      sv <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic contacts(input logic d, input logic c);
    dir_c <= d;
    clr_c <= c;
    repeat (6) @(posedge clk);
  endtask
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    {rst_b, cyc, stb, we, adr, sel, wdat, keys} = '0;
    {present, sv, tq, dir_c, clr_c, zcnt, cyc_n} = '0;
    spd = 16'h1388;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wb(0, tzf_pkg::CTRL_OFS, 0); `CHK("ctrl", 32'h400, rdat)
    wb(0, tzf_pkg::TCAP_OFS, 0); `CHK("tcap", 32'h7FFF, rdat)
    wb(0, tzf_pkg::SMAX_OFS, 0); `CHK("smax", 32'h2710, rdat)
    wb(1, tzf_pkg::STAT_OFS, 32'hFF);
    wb(0, tzf_pkg::STAT_OFS, 0); `CHK("stat ro", 32'h0, rdat)
    wb(0, 5'h02, 0); `CHK("unmapped", 32'h0, rdat)
    // pass-through filter keeps the scale checks exact
    wb(1, tzf_pkg::CTRL_OFS, 0);
    wb(1, tzf_pkg::TCAP_OFS, 32'h3E8);
    smp(16'h01F4, 1);
    wb(0, tzf_pkg::TOUT_OFS, 0); `CHK("tout", 32'h1388, rdat)
    `CHK("tq port", 16'h1388, tout)
    `CHK("spd port", 16'h1388, sout)
    key(0); `CHK("ccw", 1'b1, counterclockwise)
    smp(16'h01F4, 1);
    wb(0, tzf_pkg::TOUT_OFS, 0); `CHK("tout ccw", 32'hFFFFEC78, rdat)
    key(0); `CHK("cw", 1'b0, counterclockwise)
    present <= 1'b1;
    repeat (3) @(posedge clk); `CHK("ready", 1'b1, ready)
    // fresh clockwise sample, else the offset keeps the old sign
    smp(16'h01F4, 1);
    z0 = zcnt;
    key(1); `CHK("zero pulse", 1, zcnt - z0)
    wb(0, tzf_pkg::ZOFS_OFS, 0); `CHK("zofs", 32'h1F4, rdat)
    smp(16'h01F4, 1);
    wb(0, tzf_pkg::TOUT_OFS, 0); `CHK("tout zeroed", 32'h0, rdat)
    contacts(1'b0, 1'b1);
    z0 = zcnt;
    key(1); `CHK("zero refused", 0, zcnt - z0)
    wb(0, tzf_pkg::ZOFS_OFS, 0); `CHK("zofs kept", 32'h1F4, rdat)
    smp(16'h02BC, 1);
    wb(0, tzf_pkg::TOUT_OFS, 0); `CHK("tout clr", 32'h0, rdat)
    `CHK("tq clr", 16'h0, tout)
    `CHK("spd clr", 16'h0, sout)
    `CHK("ready clr", 1'b0, ready)
    contacts(1'b0, 1'b0);
    smp(16'h02BC, 1);
    wb(0, tzf_pkg::TOUT_OFS, 0); `CHK("tout ofs", 32'h7D0, rdat)
    wb(1, tzf_pkg::CTRL_OFS, 32'h1);
    contacts(1'b1, 1'b0); `CHK("ccw closed", 1'b1, counterclockwise)
    key(0); `CHK("key ignored", 1'b1, counterclockwise)
    contacts(1'b0, 1'b0); `CHK("cw open", 1'b0, counterclockwise)
    wb(1, tzf_pkg::CTRL_OFS, 0);
    key(2);
    wb(0, tzf_pkg::STAT_OFS, 0); `CHK("cal step0", 3'b001, rdat[4:2])
    `CHK("tq zero lvl", 16'h0, tout)
    wb(1, tzf_pkg::CENT_OFS, 32'h3E8);
    key(3);
    wb(0, tzf_pkg::STAT_OFS, 0); `CHK("zero range", 2'b00, rdat[4:3])
    wb(1, tzf_pkg::CENT_OFS, 32'h14);
    key(3);
    wb(0, tzf_pkg::STAT_OFS, 0); `CHK("step1", 2'b01, rdat[4:3])
    `CHK("tq full lvl", 16'h2710, tout)
    wb(1, tzf_pkg::CENT_OFS, 32'h2327);
    key(3);
    wb(0, tzf_pkg::STAT_OFS, 0); `CHK("full range", 2'b01, rdat[4:3])
    wb(1, tzf_pkg::CENT_OFS, 32'h2710);
    key(3);
    wb(0, tzf_pkg::STAT_OFS, 0); `CHK("step2", 2'b10, rdat[4:3])
    `CHK("spd zero lvl", 16'h0, sout)
    wb(1, tzf_pkg::CENT_OFS, 32'h14);
    key(3);
    wb(0, tzf_pkg::STAT_OFS, 0); `CHK("step3", 2'b11, rdat[4:3])
    `CHK("spd full lvl", 16'h2710, sout)
    `CHK("ready cal", 1'b0, ready)
    key(2);
    wb(0, tzf_pkg::STAT_OFS, 0); `CHK("measure", 1'b0, rdat[2])
    smp(16'h02BC, 1);
    wb(0, tzf_pkg::TOUT_OFS, 0); `CHK("corrected", 32'h7BC, rdat)
    `CHK("spd corrected", 16'h1374, sout)
    // clear empties the filter so the step starts from zero
    wb(1, tzf_pkg::CTRL_OFS, 32'h200);
    contacts(1'b0, 1'b1);
    contacts(1'b0, 1'b0);
    smp(16'h05DC, 1);
    wb(0, tzf_pkg::TOUT_OFS, 0); `CHK("lowpass", 1'b1, rdat > 0 && rdat < 3000)
    smp(16'h05DC, 3);
    wb(0, tzf_pkg::TOUT_OFS, 0); `CHK("tau", 1'b1, rdat > 6000 && rdat < 7000)
    conclude();
  end
endmodule
`default_nettype wire
